// [hw/event_queue.sv]
`timescale 1ns/1ps
module event_queue
  import host_page_pkg::*;
#(
  parameter int DEPTH = 8
) (
  input wire logic clk,
  input wire logic rstSync_n,
  event_queue_if.queue q
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  initial begin
    if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin
      $error("event_queue DEPTH must be a power of two, at least 2");
    end
  end

  logic [30:0] store [DEPTH];
  logic [AW:0] wrPtr_reg;
  logic [AW:0] rdPtr_reg;
  logic doPush;
  logic doPop;

  assign q.headValid = (wrPtr_reg != rdPtr_reg);
  assign q.pushReady = (wrPtr_reg[AW-1:0] != rdPtr_reg[AW-1:0]) ||
    (wrPtr_reg[AW] == rdPtr_reg[AW]);
  assign q.headData = store[rdPtr_reg[AW-1:0]];
  assign doPush = q.pushValid && q.pushReady;
  assign doPop = q.pop && q.headValid;

  always_ff @(posedge clk) begin
    if (doPush) begin
      store[wrPtr_reg[AW-1:0]] <= q.pushData;
    end
  end

  always_ff @(posedge clk or negedge rstSync_n) begin
    if (!rstSync_n) begin
      wrPtr_reg <= '0;
      rdPtr_reg <= '0;
    end else begin
      if (doPush) begin
        wrPtr_reg <= wrPtr_reg + 1'b1;
      end
      // Pop removes only the head entry
      if (doPop) begin
        rdPtr_reg <= rdPtr_reg + 1'b1;
      end
    end
  end
endmodule : event_queue

// [hw/event_queue_if.sv]
`timescale 1ns/1ps
interface event_queue_if;
  logic pushValid;
  logic pushReady;
  logic [30:0] pushData;
  logic headValid;
  logic [30:0] headData;
  logic pop;
  modport queue(input pushValid, input pushData, input pop,
    output pushReady, output headValid, output headData);
  modport owner(output pushValid, output pushData, output pop,
    input pushReady, input headValid, input headData);
endinterface : event_queue_if

// [hw/host_direct_page_registers.sv]
`timescale 1ns/1ps
module host_direct_page_registers
  import host_page_pkg::*;
#(
  parameter int QUEUE_DEPTH = 8,
  parameter int RESET_CYCLES = INTERNAL_RESET_CYCLES
) (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic hostSel,
  input wire logic hostWrite,
  input wire logic hostDirect,
  input wire logic [7:0] hostAddr,
  input wire logic [15:0] hostWdata,
  output logic [15:0] hostRdata,
  output logic hostAck,
  output logic memStrobe,
  output logic memWrite,
  output logic [7:0] memPage,
  output logic [POINTER_WIDTH-1:0] memOffset,
  output logic [15:0] memWdata,
  output logic [29:8] memBaseAddr,
  input wire logic [15:0] memRdata,
  input wire logic eventValid,
  input wire logic [14:0] eventIndication,
  input wire logic [15:0] eventParam,
  output logic eventReady,
  input wire logic [14:0] systemStatus,
  input wire logic [14:0] systemMask,
  input wire logic cmdRelease,
  input wire logic rspRelease,
  output logic [1:0] mailboxOwnership,
  output logic resetBusy
);
  initial begin
    if (RESET_CYCLES < 1 || RESET_CYCLES > 65535) begin
      $error("RESET_CYCLES out of range");
    end
  end

  // ****************************************************************
  // Reset release and internal reset
  // ****************************************************************
  logic [1:0] rstPipe_reg;
  logic rstSync_n;
  logic [15:0] resetCount_reg;
  logic resetBusy_reg;

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      rstPipe_reg <= 2'h0;
    end else begin
      rstPipe_reg <= {rstPipe_reg[0], 1'b1};
    end
  end
  assign rstSync_n = rstPipe_reg[1];

  always_ff @(posedge core_clk or negedge rstSync_n) begin
    if (!rstSync_n) begin
      resetCount_reg <= 16'h0000;
      resetBusy_reg <= 1'b1;
    end else if (resetBusy_reg) begin
      resetCount_reg <= resetCount_reg + 16'h0001;
      if (resetCount_reg == 16'(RESET_CYCLES - 1)) begin
        resetBusy_reg <= 1'b0;
      end
    end
  end
  assign resetBusy = resetBusy_reg;

  // ****************************************************************
  // Access decode
  // ****************************************************************
  logic directRead;
  logic directWrite;
  logic pagedAccess;
  logic regAllowed;

  assign regAllowed = !resetBusy_reg || (hostAddr == ADDR_BASE_LOW);
  assign directRead = hostSel && hostDirect && !hostWrite && regAllowed;
  assign directWrite = hostSel && hostDirect && hostWrite && regAllowed;
  assign pagedAccess = hostSel && !hostDirect && !resetBusy_reg;

  // ****************************************************************
  // Page selection and access pointer
  // ****************************************************************
  logic [7:0] pageSel_reg;
  logic [POINTER_WIDTH-1:0] pointer_reg;

  always_ff @(posedge core_clk or negedge rstSync_n) begin
    if (!rstSync_n) begin
      pageSel_reg <= 8'h00;
    end else if (directWrite && hostAddr == ADDR_PAGE_SELECTION) begin
      pageSel_reg <= hostWdata[7:0];
    end
  end

  always_ff @(posedge core_clk or negedge rstSync_n) begin
    if (!rstSync_n) begin
      pointer_reg <= '0;
    end else if (directWrite && hostAddr == ADDR_ACCESS_POINTER) begin
      pointer_reg <= hostWdata[POINTER_WIDTH-1:0];
    end else if (directWrite && hostAddr == ADDR_PAGE_SELECTION) begin
      pointer_reg <= '0;
    end else if (pagedAccess) begin
      pointer_reg <= pointer_reg + 1'b1;
    end
  end

  // ****************************************************************
  // Mailbox ownership
  // ****************************************************************
  logic [1:0] owner_reg;
  logic [1:0] hostGive;
  logic [1:0] deviceGive;

  assign hostGive = (directWrite && hostAddr == ADDR_MAILBOX_OWNER) ?
    hostWdata[1:0] : 2'h0;
  assign deviceGive = {rspRelease, cmdRelease};

  always_ff @(posedge core_clk or negedge rstSync_n) begin
    if (!rstSync_n) begin
      owner_reg <= OWNER_RESET;
    end else begin
      owner_reg <= (owner_reg & ~deviceGive) | hostGive;
    end
  end
  assign mailboxOwnership = owner_reg;

  // ****************************************************************
  // Boot checksum and page 255 base
  // ****************************************************************
  logic [31:0] checksum_reg;
  logic [13:0] baseHigh_reg;
  logic [7:0] baseLow_reg;
  logic bootWrite;

  assign bootWrite = pagedAccess && hostWrite && pageSel_reg == BOOT_PAGE;

  always_ff @(posedge core_clk or negedge rstSync_n) begin
    if (!rstSync_n) begin
      checksum_reg <= 32'h00000000;
    end else if (directWrite && hostAddr == ADDR_CHECKSUM_HIGH) begin
      checksum_reg <= {hostWdata, checksum_reg[15:0]};
    end else if (directWrite && hostAddr == ADDR_CHECKSUM_LOW) begin
      checksum_reg <= {checksum_reg[31:16], hostWdata};
    end else if (bootWrite) begin
      checksum_reg <= checksum_reg + {16'h0000, hostWdata};
    end
  end

  always_ff @(posedge core_clk or negedge rstSync_n) begin
    if (!rstSync_n) begin
      baseHigh_reg <= BASE_HIGH_RESET;
      baseLow_reg <= BASE_LOW_RESET;
    end else begin
      if (directWrite && hostAddr == ADDR_BASE_HIGH) begin
        baseHigh_reg <= hostWdata[BASE_HIGH_WIDTH-1:0];
      end
      if (directWrite && hostAddr == ADDR_BASE_LOW && !resetBusy_reg) begin
        baseLow_reg <= hostWdata[15:8];
      end
    end
  end

  // ****************************************************************
  // Interrupt sources
  // ****************************************************************
  event_queue_if evq();
  logic [14:0] statusPrev_reg;
  logic [14:0] sysPending_reg;
  logic [14:0] sysReport;
  logic [15:0] param_reg;
  logic indRead;

  event_queue #(.DEPTH(QUEUE_DEPTH)) queueInst (
    .clk(core_clk),
    .rstSync_n(rstSync_n),
    .q(evq.queue)
  );

  assign evq.pushValid = eventValid;
  assign evq.pushData = {eventIndication, eventParam};
  assign eventReady = evq.pushReady;
  assign indRead = directRead && hostAddr == ADDR_INT_INDICATION;
  assign sysReport = (indRead && sysPending_reg != 15'h0000) ? sysPending_reg : 15'h0000;
  // Queue entry removed only when reported
  assign evq.pop = indRead && sysPending_reg == 15'h0000;

  // Unmasked transitions set pending, set wins
  always_ff @(posedge core_clk or negedge rstSync_n) begin
    if (!rstSync_n) begin
      statusPrev_reg <= 15'h0000;
      sysPending_reg <= 15'h0000;
    end else begin
      statusPrev_reg <= systemStatus;
      sysPending_reg <= (sysPending_reg & ~sysReport) |
        ((systemStatus ^ statusPrev_reg) & ~systemMask);
    end
  end

  always_ff @(posedge core_clk or negedge rstSync_n) begin
    if (!rstSync_n) begin
      param_reg <= 16'h0000;
    end else if (indRead) begin
      if (sysPending_reg != 15'h0000) begin
        param_reg <= {1'b0, systemStatus};
      end else if (evq.headValid) begin
        param_reg <= evq.headData[15:0];
      end else begin
        param_reg <= 16'h0000;
      end
    end
  end

  // ****************************************************************
  // Read data and paged memory port
  // ****************************************************************
  logic [15:0] readValue;

  always_comb begin
    readValue = 16'h0000;
    if (!hostDirect) begin
      readValue = memRdata;
    end else if (regAllowed) begin
      unique case (hostAddr)
        ADDR_INT_INDICATION: begin
          if (sysPending_reg != 15'h0000) begin
            readValue = {1'b1, sysPending_reg};
          end else if (evq.headValid) begin
            readValue = {1'b0, evq.headData[30:16]};
          end else begin
            readValue = 16'h0000;
          end
        end
        ADDR_INT_PARAMETER: readValue = param_reg;
        ADDR_ACCESS_POINTER: readValue = {6'h00, pointer_reg};
        ADDR_MAILBOX_OWNER: readValue = {14'h0000, owner_reg};
        ADDR_CHECKSUM_HIGH: readValue = checksum_reg[31:16];
        ADDR_CHECKSUM_LOW: readValue = checksum_reg[15:0];
        ADDR_BASE_HIGH: readValue = {2'h0, baseHigh_reg};
        ADDR_BASE_LOW: readValue = {baseLow_reg, 7'h00, resetBusy_reg};
        default: readValue = 16'h0000;
      endcase
    end
  end

  always_ff @(posedge core_clk or negedge rstSync_n) begin
    if (!rstSync_n) begin
      hostRdata <= 16'h0000;
      hostAck <= 1'b0;
    end else begin
      hostAck <= hostSel;
      if (hostSel && !hostWrite) begin
        hostRdata <= readValue;
      end
    end
  end

  assign memStrobe = pagedAccess;
  assign memWrite = pagedAccess && hostWrite;
  assign memPage = pageSel_reg;
  assign memOffset = pointer_reg;
  assign memWdata = hostWdata;
  assign memBaseAddr = {baseHigh_reg, baseLow_reg};
endmodule : host_direct_page_registers

// [hw/host_page_pkg.sv]
package host_page_pkg;
  localparam logic [7:0] ADDR_INT_INDICATION = 8'h00;
  localparam logic [7:0] ADDR_INT_PARAMETER = 8'h01;
  localparam logic [7:0] ADDR_ACCESS_POINTER = 8'h02;
  localparam logic [7:0] ADDR_MAILBOX_OWNER = 8'h03;
  localparam logic [7:0] ADDR_CHECKSUM_HIGH = 8'h04;
  localparam logic [7:0] ADDR_CHECKSUM_LOW = 8'h05;
  localparam logic [7:0] ADDR_BASE_HIGH = 8'h06;
  localparam logic [7:0] ADDR_BASE_LOW = 8'h07;
  localparam logic [7:0] ADDR_PAGE_SELECTION = 8'hFE;
  localparam logic [7:0] BOOT_PAGE = 8'hFF;
  localparam int SOURCE_BIT = 15;
  localparam int CMD_OWNER_BIT = 0;
  localparam int RSP_OWNER_BIT = 1;
  localparam int RESET_BUSY_BIT = 0;
  localparam int POINTER_WIDTH = 10;
  localparam int BASE_HIGH_WIDTH = 14;
  localparam logic [1:0] OWNER_RESET = 2'h3;
  localparam logic [7:0] BASE_LOW_RESET = 8'hFF;
  localparam logic [13:0] BASE_HIGH_RESET = 14'h0000;
  localparam int CLK_PERIOD_NS = 40;
  localparam int INTERNAL_RESET_TIME_NS = 2000;
  localparam int INTERNAL_RESET_CYCLES =
    (INTERNAL_RESET_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
endpackage : host_page_pkg

// [verification/host_bus_model.sv]
`timescale 1ns/1ps
module host_bus_model (
  input wire logic core_clk,
  input wire logic hostAck,
  input wire logic [15:0] hostRdata,
  output logic hostSel,
  output logic hostWrite,
  output logic hostDirect,
  output logic [7:0] hostAddr,
  output logic [15:0] hostWdata,
  output int timeouts
);
  initial begin
    hostSel = 1'b0;
    hostWrite = 1'b0;
    hostDirect = 1'b1;
    hostAddr = 8'h00;
    hostWdata = 16'h0000;
    timeouts = 0;
  end
  // callers poll base low only and pass zero reserved bits
  task automatic xfer(input logic d, input logic w, input logic [7:0] a,
    input logic [15:0] wd, output logic [15:0] rd);
    int n;
    @(posedge core_clk);
    #1;
    hostSel = 1'b1;
    hostWrite = w;
    hostDirect = d;
    hostAddr = a;
    hostWdata = wd;
    @(posedge core_clk);
    #1;
    hostSel = 1'b0;
    hostAddr = ~a;
    hostWdata = ~wd;
    n = 0;
    while (hostAck !== 1'b1 && n < 4) begin
      @(posedge core_clk);
      #1;
      n++;
    end
    if (n == 4) timeouts++;
    rd = hostRdata;
  endtask : xfer
endmodule : host_bus_model

// [verification/host_direct_page_registers_asserts.sv]
`timescale 1ns/1ps
module host_direct_page_registers_asserts
  import host_page_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic hostSel,
  input wire logic hostWrite,
  input wire logic hostDirect,
  input wire logic [7:0] hostAddr,
  input wire logic [15:0] hostWdata,
  input wire logic [15:0] hostRdata,
  input wire logic memStrobe,
  input wire logic memWrite,
  input wire logic [7:0] memPage,
  input wire logic [POINTER_WIDTH-1:0] memOffset,
  input wire logic [15:0] memWdata,
  input wire logic cmdRelease,
  input wire logic [1:0] mailboxOwnership,
  input wire logic resetBusy
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  logic dirWr;
  logic setCmd;
  assign dirWr = hostSel && hostWrite && hostDirect;
  assign setCmd = dirWr && hostAddr == 8'h03 && hostWdata[0];
  property p_busy_value;
    hostSel && !hostWrite && hostDirect && hostAddr == 8'h07 && resetBusy |=> hostRdata == 16'hFF01;
  endproperty
  a_busy_value: assert property (p_busy_value) else $error("base low not busy value");
  property p_busy_refuse;
    resetBusy |-> !memStrobe;
  endproperty
  a_busy_refuse: assert property (p_busy_refuse) else $error("paged access while busy");
  property p_strobe;
    hostSel && !hostDirect && !resetBusy |-> memStrobe && memWrite == hostWrite;
  endproperty
  a_strobe: assert property (p_strobe) else $error("paged access not issued");
  property p_ptr_adv;
    memStrobe |=> memOffset == $past(memOffset) + 10'h001;
  endproperty
  a_ptr_adv: assert property (p_ptr_adv) else $error("pointer did not advance");
  property p_page_sel;
    dirWr && hostAddr == 8'hFE && !resetBusy |=> memPage == $past(hostWdata[7:0]) && memOffset == 10'h000;
  endproperty
  a_page_sel: assert property (p_page_sel) else $error("page select not taken");
  property p_release;
    cmdRelease && !setCmd |=> !mailboxOwnership[0];
  endproperty
  a_release: assert property (p_release) else $error("release did not clear");
  property p_no_claim;
    $rose(mailboxOwnership[0]) |-> $past(setCmd);
  endproperty
  a_no_claim: assert property (p_no_claim) else $error("owner bit set without host");
  property p_zero_write;
    dirWr && hostAddr == 8'h03 && !hostWdata[0] && !cmdRelease |=> $stable(mailboxOwnership[0]);
  endproperty
  a_zero_write: assert property (p_zero_write) else $error("zero write changed owner");
  property p_wdata;
    memStrobe && memWrite |-> memWdata == hostWdata;
  endproperty
  a_wdata: assert property (p_wdata) else $error("paged write data not passed");
endmodule : host_direct_page_registers_asserts
bind host_direct_page_registers host_direct_page_registers_asserts chk_u (.core_clk, .rst_n,
  .hostSel, .hostWrite, .hostDirect, .hostAddr, .hostWdata, .hostRdata, .memStrobe, .memWrite,
  .memPage, .memOffset, .memWdata, .cmdRelease, .mailboxOwnership, .resetBusy);

// [verification/host_direct_page_registers_tb.sv]
`timescale 1ns/1ps
module host_direct_page_registers_tb;
  import host_page_pkg::*;
  logic core_clk, rst_n, hostSel, hostWrite, hostDirect, hostAck, memStrobe, memWrite;
  logic eventValid, eventReady, cmdRelease, rspRelease, resetBusy;
  logic [7:0] hostAddr, memPage;
  logic [15:0] hostWdata, hostRdata, memWdata, memRdata, eventParam, rd, d;
  logic [9:0] memOffset;
  logic [29:8] memBaseAddr;
  logic [14:0] eventIndication, systemStatus, systemMask, st;
  logic [1:0] mailboxOwnership;
  logic [30:0] q[$];
  logic [30:0] e;
  logic [31:0] sum;
  int miscompares, n_tests, seed, timeouts, n;
  assign memRdata = {6'h2A, memOffset};
  host_direct_page_registers #(.RESET_CYCLES(4)) dut_u (.core_clk, .rst_n, .hostSel, .hostWrite,
    .hostDirect, .hostAddr, .hostWdata, .hostRdata, .hostAck, .memStrobe, .memWrite, .memPage,
    .memOffset, .memWdata, .memBaseAddr, .memRdata, .eventValid, .eventIndication, .eventParam,
    .eventReady, .systemStatus, .systemMask, .cmdRelease, .rspRelease, .mailboxOwnership,
    .resetBusy);
  host_bus_model host_u (.core_clk, .hostAck, .hostRdata, .hostSel, .hostWrite, .hostDirect,
    .hostAddr, .hostWdata, .timeouts);
  task automatic report_and_stop();
    $display("Comparisons %0d mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : report_and_stop
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      miscompares++;
      $display("ERROR %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check
  task automatic acc(input logic dr, input logic w, input logic [7:0] a, input logic [15:0] wd);
    host_u.xfer(dr, w, a, wd, rd);
    if (timeouts != 0) begin
      miscompares++;
      report_and_stop();
    end
  endtask : acc
  task automatic wr(input logic [7:0] a, input logic [15:0] wd);
    acc(1'b1, 1'b1, a, wd);
  endtask : wr
  task automatic rdc(input logic [7:0] a, input logic [15:0] ex);
    acc(1'b1, 1'b0, a, 16'h0000);
    check({16'h0000, rd}, {16'h0000, ex});
  endtask : rdc
  task automatic rel(input logic b);
    @(posedge core_clk);
    #1;
    cmdRelease = !b;
    rspRelease = b;
    @(posedge core_clk);
    #1;
    cmdRelease = 1'b0;
    rspRelease = 1'b0;
  endtask : rel
  initial begin
    core_clk = 1'b0;
    forever #20 core_clk = ~core_clk;
  end
  initial begin
    repeat (5000) @(posedge core_clk);
    miscompares++;
    report_and_stop();
  end
  initial begin
    seed = 39451;
    rst_n = 1'b0;
    {eventValid, cmdRelease, rspRelease, eventIndication, eventParam, systemStatus} = '0;
    systemMask = 15'h7F00;
    repeat (6) @(posedge core_clk);
    #1;
    rst_n = 1'b1;
    // Requests wait out the two-flop reset release
    repeat (2) @(posedge core_clk);
    rdc(8'h07, 16'hFF01);
    n = 0;
    while (rd !== 16'hFF00 && n < 20) begin
      acc(1'b1, 1'b0, 8'h07, 16'h0000);
      n++;
    end
    check({16'h0000, rd}, 32'h0000FF00);
    check({30'h0, mailboxOwnership}, 32'h00000003);
    $display("reset test done");
    rdc(8'h00, 16'h0000);
    rdc(8'h01, 16'h0000);
    for (int i = 0; i < 3; i++) begin
      @(posedge core_clk);
      #1;
      eventValid = 1'b1;
      check({31'h0, eventReady}, 32'h00000001);
      eventIndication = 15'($random(seed));
      eventParam = 16'($random(seed));
      q.push_back({eventIndication, eventParam});
      @(posedge core_clk);
      #1;
      eventValid = 1'b0;
    end
    st = 15'($random(seed)) | 15'h0001;
    systemStatus = st;
    rdc(8'h00, {1'b1, st & ~systemMask});
    rdc(8'h01, {1'b0, st});
    rdc(8'h01, {1'b0, st});
    while (q.size() > 0) begin
      e = q.pop_front();
      rdc(8'h00, {1'b0, e[30:16]});
      rdc(8'h01, e[15:0]);
    end
    rdc(8'h00, 16'h0000);
    $display("interrupt test done");
    wr(8'hFE, 16'h00FF);
    wr(8'h04, 16'h0001);
    wr(8'h05, 16'h0000);
    sum = 32'h00010000;
    for (int i = 0; i < 3; i++) begin
      d = 16'($random(seed));
      acc(1'b0, 1'b1, 8'h00, d);
      sum = sum + {16'h0000, d};
    end
    rdc(8'h02, 16'h0003);
    rdc(8'h04, sum[31:16]);
    rdc(8'h05, sum[15:0]);
    wr(8'hFE, 16'h0000);
    wr(8'hFE, 16'h00FF);
    wr(8'h02, 16'h03FF);
    acc(1'b0, 1'b0, 8'h00, 16'h0000);
    check({16'h0000, rd}, {16'h0000, 6'h2A, 10'h3FF});
    rdc(8'h02, 16'h0000);
    $display("pointer test done");
    wr(8'h03, 16'h0000);
    rdc(8'h03, 16'h0003);
    rel(1'b0);
    rdc(8'h03, 16'h0002);
    wr(8'h03, 16'h0001);
    rdc(8'h03, 16'h0003);
    rel(1'b1);
    rdc(8'h03, 16'h0001);
    wr(8'h03, 16'h0002);
    rdc(8'h03, 16'h0003);
    $display("mailbox test done");
    d = 16'($random(seed)) & 16'h3FFF;
    wr(8'h06, d);
    wr(8'h07, 16'hAB00);
    rdc(8'h06, d);
    rdc(8'h07, 16'hAB00);
    check(32'(memBaseAddr), {10'h000, d[13:0], 8'hAB});
    rdc(8'h30, 16'h0000);
    $display("base test done");
    report_and_stop();
  end
endmodule : host_direct_page_registers_tb
